// ===== power_mode_pkg.sv
// Package with register map, field layout, mode codes and carrier types of the power mode block
// Functional notes
// - Five modes under one power management unit
// - Idle bit 0 halts CPU after instruction
// - Idle keeps registers, memory and peripherals running
// - Enabled interrupt clears idle bit, resumes CPU
// - Handler return continues after the idle write
// - Reset ends idle, restart at 0x0000
// - Enabled watchdog expiry resets out of idle
// - Stop bit 1 halts CPU and precision oscillator
// - Only reset ends stop, restart at 0x0000
// - Missing clock detector resets out of stop
// - Low power enable gates CPU clock in idle
// - Override bit forces group clock in active
// - CPU clock never gated in low power active
// - Suspend gates system clock, stops internal oscillators
// - Sleep gates core supply, keeps RTC oscillator
// - Idle enables: four groups, zero gates clock
// - Override uses same groups, one forces clock
// - Wake flags read zero two clocks after suspend
package power_mode_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_POWER_CONTROL = 8'h00;
  localparam logic [7:0] OFS_CLOCK_MODE = 8'h04;
  localparam logic [7:0] OFS_IDLE_CLOCK_EN = 8'h08;
  localparam logic [7:0] OFS_ACTIVE_OVERRIDE = 8'h0c;
  localparam logic [7:0] OFS_PMU_CONFIG = 8'h10;
  localparam logic [7:0] OFS_WAKE_FLAGS = 8'h14;
  localparam logic [7:0] OFS_MODE_STATUS = 8'h18;

  // Field positions
  localparam int BIT_IDLE_SELECT = 0;
  localparam int BIT_STOP_SELECT = 1;
  localparam int BIT_LOW_POWER_MODE_ENABLE = 2;
  localparam int BIT_SUSPEND_SELECT = 6;
  localparam int BIT_SLEEP_SELECT = 7;
  localparam int NUM_CLOCK_GROUPS = 4;
  localparam int NUM_WAKE_SOURCES = 6;

  // Wake source bit positions
  localparam int WAKE_RTC = 0;
  localparam int WAKE_PORT_MATCH = 1;
  localparam int WAKE_COMPARATOR0 = 2;
  localparam int WAKE_RESET_PIN = 3;
  localparam int WAKE_PULSE_COUNTER = 4;
  localparam int WAKE_BATTERY_MONITOR = 5;

  // Reset values
  localparam logic [1:0] RST_POWER_CONTROL = 2'h0;
  localparam logic RST_LOW_POWER_MODE_ENABLE = 1'b0;
  localparam logic [3:0] RST_IDLE_CLOCK_EN = 4'hf;
  localparam logic [3:0] RST_ACTIVE_OVERRIDE = 4'h0;
  localparam logic [5:0] RST_WAKE_ENABLES = 6'h00;
  localparam logic [5:0] RST_WAKE_FLAGS = 6'h00;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  // Timing counts in system clocks
  localparam logic [1:0] WAKE_FLAG_HOLD_CYCLES = 2'h2;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b000,
    MODE_IDLE = 3'b001,
    MODE_STOP = 3'b010,
    MODE_SUSPEND = 3'b011,
    MODE_SLEEP = 3'b100
  } mode_t;

  // Clock and supply controls that leave the block together
  typedef struct packed {
    logic cpu_clk_en;
    logic sys_clk_en;
    logic precision_osc_en;
    logic low_power_osc_en;
    logic rtc_osc_en;
    logic core_supply_en;
  } clk_ctrl_t;

  // Group enable view shared with the gate cell
  typedef struct packed {
    logic gate_active;
    logic gate_idle;
    logic all_off;
  } gate_mode_t;

endpackage : power_mode_pkg

// ===== clock_group_gate.sv
// One peripheral clock group enable cell
`timescale 1ns/100ps
module clock_group_gate
  import power_mode_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire gate_mode_t i_gate_mode,
  input wire logic i_idle_enable,
  input wire logic i_active_force,
  output logic o_clk_en
);

  logic clk_en;
  logic next_clk_en;

  // Enable chosen from the mode; registered so the gate never sees a glitch
  always_comb
  begin
    if (i_gate_mode.all_off)
      next_clk_en = 1'b0;
    else if (i_gate_mode.gate_idle)
      next_clk_en = i_idle_enable;
    else if (i_gate_mode.gate_active)
      next_clk_en = i_active_force | i_idle_enable;
    else
      next_clk_en = 1'b1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      clk_en <= 1'b1;
    else
      clk_en <= next_clk_en;
  end

  assign o_clk_en = clk_en;

endmodule : clock_group_gate

// ===== power_mode_ctrl.sv
// Power mode sequencer with peripheral clock gating and Wishbone registers
//
// Decided for this implementation: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
module power_mode_ctrl
  import power_mode_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_instr_done,
  input wire logic i_irq_pending,
  input wire logic i_wdt_enable,
  input wire logic i_wdt_expire,
  input wire logic i_mcd_enable,
  input wire logic i_mcd_timeout,
  input wire logic [5:0] i_wake_src,
  output logic o_cpu_halt,
  output logic o_cpu_resume,
  output logic o_int_reset,
  output logic [15:0] o_restart_vector,
  output clk_ctrl_t o_clk_ctrl,
  output logic [3:0] o_periph_clk_en
);

  // Register state
  logic [1:0] power_control_reg;
  logic [1:0] next_power_control_reg;
  logic low_power_mode_enable;
  logic next_low_power_mode_enable;
  logic [3:0] idle_clock_enables;
  logic [3:0] next_idle_clock_enables;
  logic [3:0] active_clock_override;
  logic [3:0] next_active_clock_override;
  logic [5:0] wake_enables;
  logic [5:0] next_wake_enables;
  logic suspend_select;
  logic next_suspend_select;
  logic sleep_select;
  logic next_sleep_select;
  logic [5:0] wake_flags;
  logic [5:0] next_wake_flags;
  logic [1:0] hold_cnt;
  logic [1:0] next_hold_cnt;

  // Sequencer state
  mode_t mode;
  mode_t next_mode;
  logic cpu_resume;
  logic next_cpu_resume;
  logic int_reset;
  logic next_int_reset;
  clk_ctrl_t clk_ctrl;
  clk_ctrl_t next_clk_ctrl;

  // Bus state
  logic wb_ack;
  logic next_wb_ack;
  logic [31:0] wb_dat;
  logic [31:0] next_wb_dat;

  logic bus_req;
  logic wr_stb;
  logic [31:0] rd_word;
  gate_mode_t gate_mode;
  logic [5:0] wake_hit;
  logic wake_event;
  logic reset_event;

  // A request is taken once; ack falls the cycle after it rose
  assign bus_req = i_wb_cyc & i_wb_stb & ~wb_ack;
  assign wr_stb = bus_req & i_wb_we & i_wb_sel[0];

  // Enabled wake sources while suspended or asleep
  assign wake_hit = i_wake_src & wake_enables;
  assign wake_event = |wake_hit;

  // Internal reset: watchdog anywhere it runs, missing clock detector in stop
  assign reset_event = (i_wdt_enable & i_wdt_expire & (mode != MODE_SUSPEND)
                        & (mode != MODE_SLEEP))
                       | (i_mcd_enable & i_mcd_timeout & (mode == MODE_STOP));

  // Read mux; flags read zero while the unit is still updating them
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (i_wb_adr)
      OFS_POWER_CONTROL: rd_word[1:0] = power_control_reg;
      OFS_CLOCK_MODE: rd_word[BIT_LOW_POWER_MODE_ENABLE] = low_power_mode_enable;
      OFS_IDLE_CLOCK_EN: rd_word[3:0] = idle_clock_enables;
      OFS_ACTIVE_OVERRIDE: rd_word[3:0] = active_clock_override;
      OFS_PMU_CONFIG:
      begin
        rd_word[5:0] = wake_enables;
        rd_word[BIT_SUSPEND_SELECT] = suspend_select;
        rd_word[BIT_SLEEP_SELECT] = sleep_select;
      end
      OFS_WAKE_FLAGS: rd_word[5:0] = (hold_cnt != 2'h0) ? 6'h00 : wake_flags;
      OFS_MODE_STATUS:
      begin
        rd_word[2:0] = mode;
        rd_word[3] = clk_ctrl.cpu_clk_en;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Bus answer: one wait state, unmapped reads return zero
  always_comb
  begin
    next_wb_ack = bus_req;
    next_wb_dat = wb_dat;
    if (bus_req && !i_wb_we)
      next_wb_dat = rd_word;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      wb_ack <= 1'b0;
      wb_dat <= 32'h0000_0000;
    end
    else
    begin
      wb_ack <= next_wb_ack;
      wb_dat <= next_wb_dat;
    end
  end

  // Register file and mode sequencer next values
  always_comb
  begin
    next_power_control_reg = power_control_reg;
    next_low_power_mode_enable = low_power_mode_enable;
    next_idle_clock_enables = idle_clock_enables;
    next_active_clock_override = active_clock_override;
    next_wake_enables = wake_enables;
    next_suspend_select = suspend_select;
    next_sleep_select = sleep_select;
    next_wake_flags = wake_flags;
    next_hold_cnt = (hold_cnt != 2'h0) ? hold_cnt - 2'h1 : 2'h0;
    next_mode = mode;
    next_cpu_resume = 1'b0;
    next_int_reset = 1'b0;

    // Software writes come first so hardware updates below win
    if (wr_stb)
    begin
      case (i_wb_adr)
        OFS_POWER_CONTROL:
          next_power_control_reg = i_wb_dat[1:0];
        OFS_CLOCK_MODE:
          next_low_power_mode_enable = i_wb_dat[BIT_LOW_POWER_MODE_ENABLE];
        OFS_IDLE_CLOCK_EN:
          next_idle_clock_enables = i_wb_dat[3:0];
        OFS_ACTIVE_OVERRIDE:
          next_active_clock_override = i_wb_dat[3:0];
        OFS_PMU_CONFIG:
        begin
          next_wake_enables = i_wb_dat[5:0];
          next_suspend_select = i_wb_dat[BIT_SUSPEND_SELECT];
          next_sleep_select = i_wb_dat[BIT_SLEEP_SELECT];
        end
        OFS_WAKE_FLAGS:
          next_wake_flags = wake_flags & ~i_wb_dat[5:0];
        default:
          next_wake_flags = next_wake_flags;
      endcase
    end

    case (mode)
      MODE_NORMAL:
      begin
        // Mode entry waits for the writing instruction to finish
        if (i_instr_done)
        begin
          if (sleep_select)
            next_mode = MODE_SLEEP;
          else if (suspend_select)
            next_mode = MODE_SUSPEND;
          else if (power_control_reg[BIT_STOP_SELECT])
            next_mode = MODE_STOP;
          else if (power_control_reg[BIT_IDLE_SELECT])
            next_mode = MODE_IDLE;
        end
      end
      MODE_IDLE:
      begin
        // Registers untouched; only the CPU waits here
        if (i_irq_pending)
        begin
          next_power_control_reg[BIT_IDLE_SELECT] = 1'b0;
          next_cpu_resume = 1'b1;
          next_mode = MODE_NORMAL;
        end
      end
      MODE_STOP:
      begin
        // Interrupts are ignored; nothing but a reset leaves stop
        next_mode = MODE_STOP;
      end
      MODE_SUSPEND,
      MODE_SLEEP:
      begin
        next_wake_flags = next_wake_flags | wake_hit;
        if (wake_event)
        begin
          next_suspend_select = 1'b0;
          next_sleep_select = 1'b0;
          next_cpu_resume = 1'b1;
          if (mode == MODE_SUSPEND)
            next_hold_cnt = WAKE_FLAG_HOLD_CYCLES;
          next_mode = MODE_NORMAL;
        end
      end
      default:
        next_mode = MODE_NORMAL;
    endcase

    // Internal reset ends idle or stop and restarts from the vector
    if (reset_event)
    begin
      next_int_reset = 1'b1;
      next_power_control_reg = RST_POWER_CONTROL;
      next_low_power_mode_enable = RST_LOW_POWER_MODE_ENABLE;
      next_cpu_resume = 1'b0;
      next_mode = MODE_NORMAL;
    end
  end

  // Clock tree controls per mode
  always_comb
  begin
    next_clk_ctrl.cpu_clk_en = 1'b1;
    next_clk_ctrl.sys_clk_en = 1'b1;
    next_clk_ctrl.precision_osc_en = 1'b1;
    next_clk_ctrl.low_power_osc_en = 1'b1;
    next_clk_ctrl.rtc_osc_en = 1'b1;
    next_clk_ctrl.core_supply_en = 1'b1;
    case (next_mode)
      MODE_NORMAL:
        next_clk_ctrl.cpu_clk_en = 1'b1;
      MODE_IDLE:
        next_clk_ctrl.cpu_clk_en = ~next_low_power_mode_enable;
      MODE_STOP:
      begin
        // Low power and external oscillators are left as they were
        next_clk_ctrl.cpu_clk_en = 1'b0;
        next_clk_ctrl.precision_osc_en = 1'b0;
      end
      MODE_SUSPEND:
      begin
        next_clk_ctrl.cpu_clk_en = 1'b0;
        next_clk_ctrl.sys_clk_en = 1'b0;
        next_clk_ctrl.precision_osc_en = 1'b0;
        next_clk_ctrl.low_power_osc_en = 1'b0;
      end
      MODE_SLEEP:
      begin
        next_clk_ctrl.cpu_clk_en = 1'b0;
        next_clk_ctrl.sys_clk_en = 1'b0;
        next_clk_ctrl.precision_osc_en = 1'b0;
        next_clk_ctrl.low_power_osc_en = 1'b0;
        next_clk_ctrl.core_supply_en = 1'b0;
      end
      default:
        next_clk_ctrl.cpu_clk_en = 1'b1;
    endcase
  end

  // Group gating view handed to every gate cell
  always_comb
  begin
    gate_mode.all_off = (next_mode == MODE_SUSPEND) || (next_mode == MODE_SLEEP);
    gate_mode.gate_idle = (next_mode == MODE_IDLE) && next_low_power_mode_enable;
    gate_mode.gate_active = (next_mode == MODE_NORMAL) && next_low_power_mode_enable;
  end

  // All state cleared by the system reset; internal reset clears only mode, power control, low power enable and the resume pulse
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      power_control_reg <= RST_POWER_CONTROL;
      low_power_mode_enable <= RST_LOW_POWER_MODE_ENABLE;
      idle_clock_enables <= RST_IDLE_CLOCK_EN;
      active_clock_override <= RST_ACTIVE_OVERRIDE;
      wake_enables <= RST_WAKE_ENABLES;
      suspend_select <= 1'b0;
      sleep_select <= 1'b0;
      wake_flags <= RST_WAKE_FLAGS;
      hold_cnt <= 2'h0;
      mode <= MODE_NORMAL;
      cpu_resume <= 1'b0;
      int_reset <= 1'b0;
      clk_ctrl <= '{cpu_clk_en: 1'b1, sys_clk_en: 1'b1, precision_osc_en: 1'b1,
                    low_power_osc_en: 1'b1, rtc_osc_en: 1'b1, core_supply_en: 1'b1};
    end
    else
    begin
      power_control_reg <= next_power_control_reg;
      low_power_mode_enable <= next_low_power_mode_enable;
      idle_clock_enables <= next_idle_clock_enables;
      active_clock_override <= next_active_clock_override;
      wake_enables <= next_wake_enables;
      suspend_select <= next_suspend_select;
      sleep_select <= next_sleep_select;
      wake_flags <= next_wake_flags;
      hold_cnt <= next_hold_cnt;
      mode <= next_mode;
      cpu_resume <= next_cpu_resume;
      int_reset <= next_int_reset;
      clk_ctrl <= next_clk_ctrl;
    end
  end

  // One gate cell per peripheral group
  for (genvar g = 0; g < NUM_CLOCK_GROUPS; g++)
  begin : g_group
    clock_group_gate u_gate (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_gate_mode(gate_mode),
      .i_idle_enable(next_idle_clock_enables[g]),
      .i_active_force(next_active_clock_override[g]),
      .o_clk_en(o_periph_clk_en[g])
    );
  end

  assign o_wb_ack = wb_ack;
  assign o_wb_dat = wb_dat;
  assign o_cpu_halt = (mode != MODE_NORMAL);
  assign o_cpu_resume = cpu_resume;
  assign o_int_reset = int_reset;
  assign o_restart_vector = RESET_VECTOR;
  assign o_clk_ctrl = clk_ctrl;

endmodule : power_mode_ctrl

// ===== power_mode_ctrl_checker.sv
// Port checker for the power mode block
`timescale 1ns/100ps
module power_mode_checker
  import power_mode_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_instr_done,
  input wire logic i_irq_pending,
  input wire logic i_wdt_enable,
  input wire logic i_wdt_expire,
  input wire logic i_mcd_enable,
  input wire logic i_mcd_timeout,
  input wire logic o_cpu_halt,
  input wire logic o_cpu_resume,
  input wire logic o_int_reset,
  input wire logic [15:0] o_restart_vector,
  input wire clk_ctrl_t o_clk_ctrl,
  input wire logic [3:0] o_periph_clk_en
);
  logic idle_m;
  logic stop_m;
  logic quiet;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // Mode read from the clock outputs; stop halts with the precision oscillator off and every group clocked
  assign idle_m = o_cpu_halt && o_clk_ctrl.precision_osc_en;
  assign stop_m = o_cpu_halt && !o_clk_ctrl.precision_osc_en && o_periph_clk_en == 4'hf;
  assign quiet = !i_wdt_expire && !i_mcd_timeout && !o_int_reset;
  // Internal reset drops the halt within a cycle of its pulse
  sequence s_int_exit;
    o_int_reset ##[0:1] !o_cpu_halt;
  endsequence
  sequence s_irq_exit;
    o_cpu_resume && !o_cpu_halt;
  endsequence
  chk_rst_normal: assert property (
    $fell(i_sys_rst) |-> !o_cpu_halt && (&o_clk_ctrl) && o_periph_clk_en == 4'hf)
    else $error("not in normal mode after reset");
  chk_halt_cause: assert property (
    $rose(o_cpu_halt) |-> $past(i_instr_done)) else $error("halt without instruction end");
  chk_irq_exit: assert property (
    idle_m && i_irq_pending && quiet |=> s_irq_exit) else $error("interrupt did not end idle");
  chk_stop_hold: assert property (
    stop_m && quiet |=> o_cpu_halt && !o_cpu_resume) else $error("stop left without reset");
  chk_mcd_exit: assert property (
    stop_m && i_mcd_enable && i_mcd_timeout |=> s_int_exit) else $error("detector missed");
  chk_wdt_exit: assert property (
    idle_m && i_wdt_enable && i_wdt_expire |=> s_int_exit) else $error("watchdog missed");
  chk_cpu_run: assert property (
    !o_cpu_halt |-> o_clk_ctrl.cpu_clk_en) else $error("cpu clock gated while running");
  chk_stop_osc: assert property (
    stop_m |-> o_clk_ctrl.low_power_osc_en) else $error("stop touched low power osc");
  chk_suspend_osc: assert property (
    o_cpu_halt && !o_clk_ctrl.sys_clk_en |-> !o_clk_ctrl.low_power_osc_en)
    else $error("oscillator left on with clock gated");
  chk_sleep_rtc: assert property (
    !o_clk_ctrl.core_supply_en |-> o_clk_ctrl.rtc_osc_en && o_cpu_halt)
    else $error("sleep without rtc oscillator");
  chk_vector: assert property (
    o_int_reset |-> o_restart_vector == 16'h0000) else $error("restart vector wrong");
endmodule : power_mode_checker

bind power_mode_ctrl power_mode_checker i_power_mode_checker (.i_clk, .i_sys_rst,
  .i_instr_done, .i_irq_pending, .i_wdt_enable, .i_wdt_expire, .i_mcd_enable,
  .i_mcd_timeout, .o_cpu_halt, .o_cpu_resume, .o_int_reset, .o_restart_vector,
  .o_clk_ctrl, .o_periph_clk_en);

// ===== cpu_model.sv
// CPU stand-in that retires instructions while not halted
`timescale 1ns/100ps
module cpu_model
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_slow,
  input wire logic i_halt,
  output logic o_instr_done
);
  logic phase;
  logic next_phase;
  logic next_done;
  // A halted core retires nothing; slow mode retires every other cycle
  always_comb
  begin
    next_phase = !phase;
    next_done = !i_halt && (!i_slow || phase);
  end
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      phase <= 1'b0;
      o_instr_done <= 1'b0;
    end
    else
    begin
      phase <= next_phase;
      o_instr_done <= next_done;
    end
  end
endmodule : cpu_model

// ===== power_mode_ctrl_tb.sv
// Self-checking bench for the power mode block
`timescale 1ns/100ps
module power_mode_ctrl_tb
  import power_mode_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, irq = 1'b0, slow = 1'b0;
  logic wdt_en = 1'b0, wdt_exp = 1'b0, mcd_en = 1'b0, mcd_to = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic [5:0] wake = 6'h00;
  logic done, ack, halt, resume, irst, saw_rst;
  logic [31:0] rdat, q;
  logic [15:0] vec;
  clk_ctrl_t cc;
  logic [3:0] pclk;
  int n_fail = 0, n_tests = 0, cycles = 0;
  int mdl [8] = '{0, 0, 15, 0, 0, 0, 8, 0};
  int msk [8] = '{3, 4, 15, 15, 255, 0, 0, 0};

  always #5 i_clk = ~i_clk;

  cpu_model i_cpu_model (.i_clk, .i_sys_rst, .i_slow(slow), .i_halt(halt), .o_instr_done(done));
  power_mode_ctrl i_power_mode_ctrl (.i_clk, .i_sys_rst, .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(dat), .i_wb_sel(sel), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_instr_done(done), .i_irq_pending(irq), .i_wdt_enable(wdt_en),
    .i_wdt_expire(wdt_exp), .i_mcd_enable(mcd_en), .i_mcd_timeout(mcd_to), .i_wake_src(wake),
    .o_cpu_halt(halt), .o_cpu_resume(resume), .o_int_reset(irst), .o_restart_vector(vec),
    .o_clk_ctrl(cc), .o_periph_clk_en(pclk));

  task automatic end_sim();
    $display("comparisons=%0d mismatches=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One classic cycle, entered just after a rising edge; the timeout bounds the wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
    @(posedge i_clk);
    while (ack !== 1'b1)
      @(posedge i_clk);
    q = rdat;
    {cyc, stb} <= 2'b00;
    @(posedge i_clk);
  endtask : wb

  // Writes keep the model in step; wake flags clear where ones are written
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
    if (a < OFS_WAKE_FLAGS)
      mdl[a[4:2]] = d & msk[a[4:2]];
    else if (a == OFS_WAKE_FLAGS)
      mdl[5] = mdl[5] & ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(q, mdl[a[4:2]]);
  endtask : rd

  // Waits for halt high (0), a resume pulse (1) or halt low (2)
  task automatic till(input int k);
    while (!(k == 0 ? halt === 1'b1 : k == 1 ? resume === 1'b1 : halt === 1'b0))
      @(posedge i_clk);
  endtask : till

  always @(posedge i_clk)
  begin
    cycles++;
    if (irst === 1'b1)
      saw_rst <= 1'b1;
    if (cycles == 20000)
    begin
      n_fail++;
      end_sim();
    end
  end

  initial
  begin
    int r;
    int o;
    int k;
    r = $urandom(88);
    repeat (16) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    chk({22'h0, cc, pclk}, 32'h3ff);
    for (k = 0; k < 8; k++)
      rd(8'(k * 4));
    wb(1'b1, OFS_POWER_CONTROL, 32'h1, 4'he);
    wb(1'b1, 8'h1c, 32'hff, 4'hf);
    repeat (4) @(posedge i_clk);
    chk(halt, 1'b0);
    rd(OFS_POWER_CONTROL);
    $display("test reset and refusals done");
    // Plain and low power idle, random groups, software order kept
    for (k = 0; k < 4; k++)
    begin
      r = $urandom % 16;
      o = $urandom % 16;
      slow <= k[0];
      wr(OFS_IDLE_CLOCK_EN, r);
      wr(OFS_ACTIVE_OVERRIDE, o);
      wr(OFS_CLOCK_MODE, k[1] ? 4 : 0);
      chk(pclk, k[1] ? (o | r) : 15);
      chk(cc.cpu_clk_en, 1'b1);
      wr(OFS_POWER_CONTROL, 1);
      till(0);
      chk(cc.cpu_clk_en, !k[1]);
      chk(pclk, k[1] ? r : 15);
      irq <= 1'b1;
      till(1);
      irq <= 1'b0;
      mdl[0] = 0;
      chk(halt, 1'b0);
      rd(OFS_POWER_CONTROL);
    end
    $display("test idle done");
    // Stop ignores interrupts and wake lines until the detector fires
    wr(OFS_CLOCK_MODE, 0);
    mcd_en <= 1'b1;
    wr(OFS_POWER_CONTROL, 2);
    till(0);
    {irq, wake} <= 7'h7f;
    repeat (5) @(posedge i_clk);
    chk(halt, 1'b1);
    chk({cc.precision_osc_en, cc.low_power_osc_en}, 2'b01);
    saw_rst <= 1'b0;
    mcd_to <= 1'b1;
    @(posedge i_clk);
    {mcd_to, irq, wake} <= 8'h00;
    till(2);
    // The reset flag lands by non-blocking assignment on the edge that ends the halt
    @(posedge i_clk);
    chk(saw_rst, 1'b1);
    mdl[0] = 0;
    rd(OFS_POWER_CONTROL);
    $display("test stop done");
    // Watchdog ends low power idle; the internal reset clears the enable too
    wdt_en <= 1'b1;
    wr(OFS_CLOCK_MODE, 4);
    wr(OFS_POWER_CONTROL, 1);
    till(0);
    saw_rst <= 1'b0;
    wdt_exp <= 1'b1;
    @(posedge i_clk);
    wdt_exp <= 1'b0;
    till(2);
    @(posedge i_clk);
    chk(saw_rst, 1'b1);
    chk(vec, 16'h0000);
    mdl[0] = 0;
    mdl[1] = 0;
    rd(OFS_POWER_CONTROL);
    rd(OFS_CLOCK_MODE);
    $display("test watchdog done");
    // Suspend then sleep, each woken by one random enabled source
    for (k = 0; k < 2; k++)
    begin
      o = $urandom % 6;
      wr(OFS_PMU_CONFIG, (k ? 32'h80 : 32'h40) | (1 << o));
      till(0);
      chk({cc.sys_clk_en, cc.precision_osc_en, cc.low_power_osc_en, pclk}, 0);
      chk({cc.core_supply_en, cc.rtc_osc_en | !k[0]}, {!k[0], 1'b1});
      wake <= 6'(1 << o);
      till(1);
      wake <= 6'h00;
      mdl[4] = 1 << o;
      // Suspend hides the flags for two clocks; sleep shows them at once
      mdl[5] = k ? 1 << o : 0;
      rd(OFS_WAKE_FLAGS);
      mdl[5] = 1 << o;
      repeat (3) @(posedge i_clk);
      rd(OFS_WAKE_FLAGS);
      rd(OFS_PMU_CONFIG);
      wr(OFS_WAKE_FLAGS, 63);
      rd(OFS_WAKE_FLAGS);
    end
    $display("test suspend and sleep done");
    end_sim();
  end
endmodule : power_mode_ctrl_tb
